/* File: hdl/pcint_defines.svh */
`ifndef PCINT_DEFINES_SVH
`define PCINT_DEFINES_SVH

// operation codes
`define PCINT_OP_SECTOR_JUMP 4'h0
`define PCINT_OP_LOAD        4'h1
`define PCINT_OP_STORE       4'h2
`define PCINT_OP_TRANSFER    4'h3
`define PCINT_OP_DATA_SECTOR 4'h4
`define PCINT_OP_IO          4'h5

// instruction field positions
`define PCINT_OP_MSB   12
`define PCINT_OP_LSB   9
`define PCINT_ADR_MSB  8
`define PCINT_RES_BIT  8
`define PCINT_LOC_MSB  7

// fixed locations and I/O addresses
`define PCINT_INT_VEC_LOC  8'h00
`define PCINT_JUMP_SAVE_ADR 9'h1ff
`define PCINT_IO_INT_RESET 9'h018

// reset values
`define PCINT_SECT_RST 4'h0
`define PCINT_IC_RST   8'h00

// serial transfer length minus one
`define PCINT_SHIFT_LAST 4'hc
// cycles a request is ignored after an acknowledge
`define PCINT_ACK_HOLD 2'h3

`endif

/* File: hdl/pcint_pkg.sv */
package pcint_pkg;

	// memory address as seen by the decoders
	typedef struct packed {
		logic [3:0] sector;
		logic       residual;
		logic [7:0] loc;
	} pcint_maddr_t;

	// stored syllable with its parity bit on top
	typedef struct packed {
		logic        par;
		logic [12:0] data;
	} pcint_word_t;

	// sequencer states
	typedef enum logic [3:0] {
		S_IDLE   = 4'b0000,
		S_INT    = 4'b0001,
		S_ISAVE  = 4'b0010,
		S_IFETCH = 4'b0011,
		S_IDEC   = 4'b0100,
		S_ILOAD  = 4'b0101,
		S_EXEC   = 4'b0110,
		S_DREAD  = 4'b0111,
		S_DLATCH = 4'b1000,
		S_SHIFT  = 4'b1001,
		S_DWRITE = 4'b1010,
		S_JLOAD  = 4'b1011,
		S_IOWR   = 4'b1100
	} pcint_state_t;

endpackage

/* File: hdl/pcint_sync.sv */
`timescale 1ns/1ps
// two-stage synchroniser for pin inputs
module pcint_sync (
	input  wire logic core_clk_i,
	input  wire logic srst_i,
	input  wire logic d_i,
	output logic      q_o
);
	logic meta_q;
	logic sync_q;

	// first stage feeds only the second
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= d_i;
			sync_q <= meta_q;
		end
	end

	assign q_o = sync_q;
endmodule // pcint_sync

/* File: hdl/pcint_parity.sv */
`timescale 1ns/1ps
// odd parity generator and checker for one syllable
module pcint_parity (
	input  wire logic [12:0] data_i,
	input  wire logic        par_i,
	output logic             par_o,
	output logic             ok_o
);
	// fill bit makes the count of ones odd
	assign par_o = ~(^data_i);
	// even total means a bad syllable
	assign ok_o  = ^{par_i, data_i};
endmodule // pcint_parity

/* File: hdl/pcint_top.sv */
`timescale 1ns/1ps
`include "pcint_defines.svh"
module pcint_top (
	input  wire logic                  core_clk_i,
	input  wire logic                  srst_i,
	input  wire logic                  run_i,
	input  wire logic                  int_req_i,
	input  wire pcint_pkg::pcint_word_t mem_rdata_i,
	output logic                       mem_rd_o,
	output logic                       mem_wr_o,
	output pcint_pkg::pcint_maddr_t    mem_addr_o,
	output pcint_pkg::pcint_word_t     mem_wdata_o,
	output logic                       io_wr_o,
	output logic [8:0]                 io_addr_o,
	output logic [12:0]                io_data_o,
	output logic                       int_taken_o,
	output logic                       par_err_o,
	output logic [12:0]                acc_o,
	output logic [7:0]                 ic_o
);
	import pcint_pkg::*;

	pcint_state_t st_q,    st_d;
	logic [12:0]  xfer_q,  xfer_d;
	logic [12:0]  acc_q,   acc_d;
	logic [8:0]   addr_q,  addr_d;
	logic [7:0]   ic_q,    ic_d;
	logic         res_q,   res_d;
	logic [3:0]   isect_q, isect_d;
	logic [3:0]   dsect_q, dsect_d;
	logic [3:0]   op_q,    op_d;
	logic [3:0]   cnt_q,   cnt_d;
	logic         dph_q,   dph_d;
	logic         taken_q, taken_d;
	logic         perr_q,  perr_d;
	logic [1:0]   hold_q,  hold_d;
	logic         run_s;
	logic         irq_s;
	logic         wr_par;
	logic         rd_ok;

	// pin inputs cross two flip-flops
	pcint_sync u_run_sync (
		.core_clk_i (core_clk_i),
		.srst_i     (srst_i),
		.d_i        (run_i),
		.q_o        (run_s)
	);

	pcint_sync u_irq_sync (
		.core_clk_i (core_clk_i),
		.srst_i     (srst_i),
		.d_i        (int_req_i),
		.q_o        (irq_s)
	);

	// one checker on the read path, one generator on the write path
	pcint_parity u_rd_par (
		.data_i (mem_rdata_i.data),
		.par_i  (mem_rdata_i.par),
		.par_o  (),
		.ok_o   (rd_ok)
	);

	pcint_parity u_wr_par (
		.data_i (xfer_q),
		.par_i  (1'b0),
		.par_o  (wr_par),
		.ok_o   ()
	);

	// sequencer next-state logic
	always_comb begin
		st_d    = st_q;
		xfer_d  = xfer_q;
		acc_d   = acc_q;
		addr_d  = addr_q;
		ic_d    = ic_q;
		res_d   = res_q;
		isect_d = isect_q;
		dsect_d = dsect_q;
		op_d    = op_q;
		cnt_d   = cnt_q;
		dph_d   = dph_q;
		taken_d = taken_q;
		perr_d  = 1'b0;
		// adapter and synchronisers need a few cycles to drop an acknowledged request
		hold_d  = (hold_q != 2'h0) ? hold_q - 2'h1 : 2'h0;
		case (st_q)
			S_IDLE: begin
				// instruction boundary: stop, interrupt or fetch
				if (run_s && irq_s && !taken_q && hold_q == 2'h0) begin
					st_d = S_INT;
				end else if (run_s) begin
					addr_d = {res_q, ic_q};
					dph_d  = 1'b0;
					st_d   = S_IFETCH;
				end
			end
			S_INT: begin
				// return jump constant goes to the save word
				xfer_d = {isect_q, res_q, ic_q};
				addr_d = `PCINT_JUMP_SAVE_ADR;
				dph_d  = 1'b1;
				st_d   = S_ISAVE;
			end
			S_ISAVE: begin
				// forced jump to location 400
				ic_d    = `PCINT_INT_VEC_LOC;
				res_d   = 1'b1;
				taken_d = 1'b1;
				st_d    = S_IDLE;
			end
			S_IFETCH: begin
				st_d = S_IDEC;
			end
			S_IDEC: begin
				xfer_d = mem_rdata_i.data;
				perr_d = !rd_ok;
				st_d   = S_ILOAD;
			end
			S_ILOAD: begin
				// opcode and operand address leave the transfer register
				op_d   = xfer_q[`PCINT_OP_MSB:`PCINT_OP_LSB];
				addr_d = xfer_q[`PCINT_ADR_MSB:0];
				dph_d  = 1'b1;
				ic_d   = ic_q + 8'h01;
				st_d   = S_EXEC;
			end
			S_EXEC: begin
				// decoded opcode starts the operation
				case (op_q)
					`PCINT_OP_SECTOR_JUMP: st_d = S_DREAD;
					`PCINT_OP_LOAD:        st_d = S_DREAD;
					`PCINT_OP_STORE: begin
						cnt_d = 4'h0;
						st_d  = S_SHIFT;
					end
					`PCINT_OP_TRANSFER: begin
						ic_d  = addr_q[`PCINT_LOC_MSB:0];
						res_d = 1'b0;
						st_d  = S_IDLE;
					end
					`PCINT_OP_DATA_SECTOR: begin
						dsect_d = addr_q[3:0];
						st_d    = S_IDLE;
					end
					`PCINT_OP_IO: st_d = S_IOWR;
					default:      st_d = S_IDLE;
				endcase
			end
			S_DREAD: begin
				st_d = S_DLATCH;
			end
			S_DLATCH: begin
				xfer_d = mem_rdata_i.data;
				perr_d = !rd_ok;
				cnt_d  = 4'h0;
				if (op_q == `PCINT_OP_SECTOR_JUMP) begin
					st_d = S_JLOAD;
				end else begin
					st_d = S_SHIFT;
				end
			end
			S_SHIFT: begin
				// serial move between transfer register and accumulator
				if (op_q == `PCINT_OP_STORE) begin
					xfer_d = {acc_q[0], xfer_q[12:1]};
				end else begin
					xfer_d = {1'b0, xfer_q[12:1]};
				end
				if (op_q == `PCINT_OP_STORE) begin
					acc_d = {acc_q[0], acc_q[12:1]};
				end else begin
					acc_d = {xfer_q[0], acc_q[12:1]};
				end
				cnt_d = cnt_q + 4'h1;
				if (cnt_q == `PCINT_SHIFT_LAST) begin
					st_d = (op_q == `PCINT_OP_STORE) ? S_DWRITE : S_IDLE;
				end
			end
			S_DWRITE: begin
				st_d = S_IDLE;
			end
			S_JLOAD: begin
				// jump word sets counter, residual latch and both sectors
				ic_d    = xfer_q[`PCINT_LOC_MSB:0];
				res_d   = xfer_q[`PCINT_RES_BIT];
				isect_d = xfer_q[`PCINT_OP_MSB:`PCINT_OP_LSB];
				dsect_d = xfer_q[`PCINT_OP_MSB:`PCINT_OP_LSB];
				st_d    = S_IDLE;
			end
			S_IOWR: begin
				// reset write to the adapter ends the interrupt
				if (addr_q == `PCINT_IO_INT_RESET) begin
					taken_d = 1'b0;
					hold_d  = `PCINT_ACK_HOLD;
				end
				st_d = S_IDLE;
			end
			default: st_d = S_IDLE;
		endcase
	end

	// sequencer registers
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			st_q    <= S_IDLE;
			xfer_q  <= 13'h0000;
			acc_q   <= 13'h0000;
			addr_q  <= 9'h000;
			ic_q    <= `PCINT_IC_RST;
			res_q   <= 1'b0;
			isect_q <= `PCINT_SECT_RST;
			dsect_q <= `PCINT_SECT_RST;
			op_q    <= 4'h0;
			cnt_q   <= 4'h0;
			dph_q   <= 1'b0;
			taken_q <= 1'b0;
			perr_q  <= 1'b0;
			hold_q  <= 2'h0;
		end else begin
			st_q    <= st_d;
			xfer_q  <= xfer_d;
			acc_q   <= acc_d;
			addr_q  <= addr_d;
			ic_q    <= ic_d;
			res_q   <= res_d;
			isect_q <= isect_d;
			dsect_q <= dsect_d;
			op_q    <= op_d;
			cnt_q   <= cnt_d;
			dph_q   <= dph_d;
			taken_q <= taken_d;
			perr_q  <= perr_d;
			hold_q  <= hold_d;
		end
	end

	// memory decoder drive from address register and sectors
	assign mem_addr_o.sector   = dph_q ? dsect_q : isect_q;
	assign mem_addr_o.residual = addr_q[`PCINT_RES_BIT];
	assign mem_addr_o.loc      = addr_q[`PCINT_LOC_MSB:0];
	assign mem_rd_o            = (st_q == S_IFETCH) || (st_q == S_DREAD);
	assign mem_wr_o            = (st_q == S_DWRITE) || (st_q == S_ISAVE);
	assign mem_wdata_o.par     = wr_par;
	assign mem_wdata_o.data    = xfer_q;

	// adapter side and status
	assign io_wr_o     = (st_q == S_IOWR);
	assign io_addr_o   = addr_q;
	assign io_data_o   = acc_q;
	assign int_taken_o = taken_q;
	assign par_err_o   = perr_q;
	assign acc_o       = acc_q;
	assign ic_o        = ic_q;

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (srst_i);

	// checks
	int_jump_a: assert property (st_q == S_ISAVE |=> ic_q == 8'h00 && res_q && taken_q)
		else $error("interrupt did not land at 400");
	no_reentry_a: assert property ((st_q == S_IDLE && taken_q) |=> st_q != S_INT)
		else $error("second interrupt before acknowledge");
	ack_hold_a: assert property (io_wr_o && io_addr_o == `PCINT_IO_INT_RESET |=>
		(st_q != S_INT) [*3])
		else $error("stale request taken after acknowledge");
	save_const_a: assert property (st_q == S_INT |=> mem_wr_o &&
		xfer_q == {$past(isect_q), $past(res_q), $past(ic_q)})
		else $error("return constant wrong");
	odd_store_a: assert property (mem_wr_o |-> ^mem_wdata_o == 1'b1)
		else $error("stored syllable not odd");
	shift_len_a: assert property (st_q == S_EXEC && op_q == `PCINT_OP_STORE |=>
		##13 st_q == S_DWRITE)
		else $error("store shift length wrong");
	even_flag_a: assert property ((st_q == S_IDEC || st_q == S_DLATCH) &&
		!(^mem_rdata_i) |=> par_err_o)
		else $error("even parity read not flagged");
	stop_hold_a: assert property ((st_q == S_IDLE && !run_s) |=> st_q == S_IDLE)
		else $error("ran while stopped");
	jump_sect_a: assert property (st_q == S_JLOAD |=> isect_q == dsect_q &&
		isect_q == $past(xfer_q[12:9]))
		else $error("jump did not load both sectors");
	data_sect_a: assert property ((st_q == S_EXEC && op_q == `PCINT_OP_DATA_SECTOR)
		|=> dsect_q == $past(addr_q[3:0]) && isect_q == $past(isect_q))
		else $error("data sector change wrong");
	ic_step_a: assert property (st_q == S_ILOAD |=> ic_q == $past(ic_q) + 8'h01)
		else $error("counter did not advance");
	resid_low_a: assert property ((st_q == S_EXEC && op_q == `PCINT_OP_TRANSFER)
		|=> !res_q ##1 (st_q != S_IFETCH || !mem_addr_o.residual))
		else $error("residual latch not forced low");
	fetch_addr_a: assert property (st_q == S_IFETCH |-> addr_q == {res_q, ic_q} &&
		mem_addr_o.sector == isect_q)
		else $error("fetch address wrong");
	load_from_xfer_a: assert property (st_q == S_ILOAD |=>
		addr_q == $past(xfer_q[8:0]) && op_q == $past(xfer_q[12:9]))
		else $error("address register not loaded from transfer");

	// main scenarios
	int_taken_c: cover property (st_q == S_INT ##2 st_q == S_IDLE ##[1:40] io_wr_o);
	store_c:     cover property (st_q == S_SHIFT ##[13:14] mem_wr_o);
	jump_c:      cover property (st_q == S_JLOAD);
	noop_c:      cover property (st_q == S_EXEC && op_q > `PCINT_OP_IO);
	ack_c:       cover property (io_wr_o ##1 st_q == S_IDLE ##1 st_q == S_IFETCH);
endmodule // pcint_top

/* File: tb/pcint_far_model.sv */
`timescale 1ns/1ps
// memory array and data adapter facing the computer
module pcint_far_model (
	input  wire logic                   core_clk_i,
	input  wire logic                   srst_i,
	input  wire logic                   mem_rd_i,
	input  wire logic                   mem_wr_i,
	input  wire pcint_pkg::pcint_maddr_t mem_addr_i,
	input  wire pcint_pkg::pcint_word_t  mem_wdata_i,
	output pcint_pkg::pcint_word_t       mem_rdata_o,
	input  wire logic                   io_wr_i,
	input  wire logic [8:0]             io_addr_i,
	input  wire logic [12:0]            io_data_i,
	input  wire logic [11:0]            src_i,
	output logic                        int_req_o
);
	import pcint_pkg::*;
	pcint_word_t mem [8192];
	logic [11:0] stor_q;
	logic [11:0] mask_q;
	logic [11:0] src_q;
	logic [12:0] idx;
	logic        ack;
	// residual area ignores the sector
	assign idx = {mem_addr_i.residual ? 4'h0 : mem_addr_i.sector, mem_addr_i.residual,
		mem_addr_i.loc};
	assign ack = io_wr_i && (io_addr_i == 9'h018);
	// data the cycle after the strobe, idle bus inverts its value every cycle, alternating inverted and true last word
	always @(posedge core_clk_i) begin
		if (srst_i) begin
			mem_rdata_o <= 14'h1555;
		end else begin
			mem_rdata_o <= mem_rd_i ? mem[idx] : ~mem_rdata_o;
		end
		if (mem_wr_i) begin
			mem[idx] <= mem_wdata_i;
		end
	end
	// twelve storage bits set on source edges, suppression while still active
	always @(posedge core_clk_i) begin
		src_q <= src_i;
		if (srst_i) begin
			stor_q <= 12'h000;
			mask_q <= 12'h000;
		end else begin
			stor_q <= (stor_q | (src_i & ~src_q)) & ~(ack ? io_data_i[11:0] : 12'h000);
			mask_q <= (mask_q & src_i) | (ack ? io_data_i[11:0] & src_i : 12'h000);
		end
	end
	// one merged request
	assign int_req_o = |(stor_q & ~mask_q);
endmodule // pcint_far_model

/* File: tb/tb.sv */
`timescale 1ns/1ps
`include "pcint_defines.svh"
module tb;
	import pcint_pkg::*;
	logic         clk = 1'b0;
	logic         srst = 1'b1;
	logic         run = 1'b0;
	logic [11:0]  src = 12'h000;
	logic         int_req;
	pcint_word_t  rdata;
	pcint_word_t  wdata;
	pcint_maddr_t maddr;
	logic         mem_rd;
	logic         mem_wr;
	logic         io_wr;
	logic         int_taken;
	logic         par_err;
	logic [8:0]   io_addr;
	logic [8:0]   io_seen;
	logic [12:0]  io_data;
	logic [12:0]  io_dseen;
	logic [12:0]  acc;
	logic [7:0]   ic;
	int           error_cnt = 0;
	int           checks_done = 0;
	int           par_cnt = 0;
	int           int_cnt = 0;
	int           rd_cnt = 0;
	int           snap;
	int           n;
	logic [31:0]  seed = 32'h7ea9;
	logic [12:0]  va;
	logic [12:0]  vb;
	logic [12:0]  vc;
	logic [12:0]  vd;
	logic [3:0]   k;

	always #50 clk = ~clk;

	pcint_top u_dut (.core_clk_i(clk), .srst_i(srst), .run_i(run), .int_req_i(int_req),
		.mem_rdata_i(rdata), .mem_rd_o(mem_rd), .mem_wr_o(mem_wr), .mem_addr_o(maddr),
		.mem_wdata_o(wdata), .io_wr_o(io_wr), .io_addr_o(io_addr), .io_data_o(io_data),
		.int_taken_o(int_taken), .par_err_o(par_err), .acc_o(acc), .ic_o(ic));
	pcint_far_model u_mem (.core_clk_i(clk), .srst_i(srst), .mem_rd_i(mem_rd),
		.mem_wr_i(mem_wr), .mem_addr_i(maddr), .mem_wdata_i(wdata), .mem_rdata_o(rdata),
		.io_wr_i(io_wr), .io_addr_i(io_addr), .io_data_i(io_data), .src_i(src),
		.int_req_o(int_req));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// syllable with odd total of ones
	function automatic pcint_word_t good(logic [12:0] d);
		return {~^d, d};
	endfunction
	task automatic put(logic [3:0] s, logic r, logic [7:0] l, pcint_word_t w);
		u_mem.mem[{r ? 4'h0 : s, r, l}] = w;
	endtask
	task automatic chk(string what, logic [13:0] exp, logic [13:0] got);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	// bounded wait for a read strobe, fetch or data read, at residual bit plus location
	task automatic wait_addr(logic [8:0] a);
		for (n = 0; n < 3000 && !(mem_rd === 1'b1 && maddr[8:0] === a); n++) @(negedge clk);
		chk("fetch wait", 14'h0, (n == 3000) ? 14'h1 : 14'h0);
	endtask
	task automatic wait_taken(logic v);
		for (n = 0; n < 3000 && int_taken !== v; n++) @(negedge clk);
		chk("service wait", 14'h0, (n == 3000) ? 14'h1 : 14'h0);
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// event counters and I/O capture
	always @(posedge clk) begin
		if (par_err === 1'b1) par_cnt++;
		if ($rose(int_taken)) int_cnt++;
		if (mem_rd === 1'b1) rd_cnt++;
		if (io_wr === 1'b1) begin
			io_seen <= io_addr;
			io_dseen <= io_data;
		end
	end

	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		give_verdict();
	end

	// program, data and handler images, then the run
	initial begin
		va = 13'(rnd());
		vb = 13'(rnd());
		vc = 13'(rnd());
		vd = 13'(rnd());
		k = 4'(rnd() % 12);
		put(4'h0, 1'b0, 8'h00, good({`PCINT_OP_LOAD, 9'h040}));
		put(4'h0, 1'b0, 8'h01, good({`PCINT_OP_STORE, 9'h041}));
		put(4'h0, 1'b0, 8'h02, good({`PCINT_OP_LOAD, 9'h042}));
		put(4'h0, 1'b0, 8'h03, good({`PCINT_OP_DATA_SECTOR, 9'h003}));
		put(4'h0, 1'b0, 8'h04, good({`PCINT_OP_LOAD, 9'h043}));
		put(4'h0, 1'b0, 8'h05, good({`PCINT_OP_STORE, 9'h046}));
		put(4'h0, 1'b0, 8'h06, good({`PCINT_OP_SECTOR_JUMP, 9'h044}));
		put(4'h0, 1'b0, 8'h40, good(va));
		put(4'h0, 1'b0, 8'h42, {^vb, vb});
		put(4'h3, 1'b0, 8'h43, good(vc));
		put(4'h3, 1'b0, 8'h44, good({4'h5, 1'b0, 8'h10}));
		put(4'h5, 1'b0, 8'h10, good({4'hf, 9'h000}));
		put(4'h5, 1'b0, 8'h11, good({`PCINT_OP_TRANSFER, 9'h020}));
		put(4'h5, 1'b0, 8'h20, good({`PCINT_OP_LOAD, 9'h045}));
		put(4'h5, 1'b0, 8'h21, good({`PCINT_OP_TRANSFER, 9'h021}));
		put(4'h5, 1'b0, 8'h45, good(vd));
		put(4'h0, 1'b1, 8'h00, good({`PCINT_OP_LOAD, 9'h180}));
		put(4'h0, 1'b1, 8'h01, good({`PCINT_OP_IO, 9'h018}));
		put(4'h0, 1'b1, 8'h02, good({`PCINT_OP_SECTOR_JUMP, 9'h1ff}));
		put(4'h0, 1'b1, 8'h80, good(13'h0001 << k));
		repeat (20) @(negedge clk);
		srst = 1'b0;
		run = 1'b1;
		wait_addr(9'h021);
		chk("store a", good(va), u_mem.mem[13'h0041]);
		chk("store c", good(vc), u_mem.mem[13'h0646]);
		chk("parity errors", 14'h1, 14'(par_cnt));
		chk("acc d", {1'b0, vd}, {1'b0, acc});
		chk("spin sector", 14'h5, {10'h0, maddr.sector});
		src[k] = 1'b1;
		wait_taken(1'b1);
		wait_addr(9'h100);
		wait_taken(1'b0);
		chk("io addr", {5'h0, 9'h018}, {5'h0, io_seen});
		chk("io data", {1'b0, 13'h0001 << k}, {1'b0, io_dseen});
		chk("return word", good({4'h5, 1'b0, 8'h21}), u_mem.mem[13'h01ff]);
		wait_addr(9'h021);
		chk("interrupts", 14'h1, 14'(int_cnt));
		src[k] = 1'b0;
		repeat (10) @(negedge clk);
		src[k] = 1'b1;
		wait_taken(1'b1);
		wait_taken(1'b0);
		wait_addr(9'h021);
		chk("interrupts again", 14'h2, 14'(int_cnt));
		run = 1'b0;
		repeat (50) @(negedge clk);
		snap = rd_cnt;
		repeat (100) @(negedge clk);
		chk("stopped reads", 14'(snap), 14'(rd_cnt));
		chk("stopped ic", 14'h21, {6'h0, ic});
		give_verdict();
	end
endmodule // tb
